// ==== hw/rcs_pkg.sv ====
/*
  Constants, types and decode helpers of the reset and configuration
  sequencer. Assumes a 10 MHz reference clock and APB register access.
*/
package rcs_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MASTER_CLEAR_PIN_MIN_NS   = 2000;
  localparam int MASTER_CLEAR_PIN_MIN_CYC  = (MASTER_CLEAR_PIN_MIN_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int MASTER_CLEAR_PIN_W        = $clog2(MASTER_CLEAR_PIN_MIN_CYC + 1);
  localparam int OST_TOSC      = 1024;
  localparam int POWERUP_TIMER_MS       = 72;
  localparam int WDT_MS        = 18;
  localparam int NS_PER_MS     = 1000000;
  localparam int POWERUP_TIMER_CYC_DEF  = POWERUP_TIMER_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int WDT_CYC_DEF   = WDT_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int DLY_W         = 24;
  localparam int PC_W          = 13;
  localparam logic [12:0] PC_RESET  = 13'h0000;
  localparam logic [12:0] PC_VECTOR = 13'h0004;
  localparam logic [7:0]  DIR_RST   = 8'hff;

  // Register indices; byte address is four times the index
  localparam logic [15:0] CFG_IDX  = 16'h2007;
  localparam logic [15:0] CTRL_IDX = 16'h0001;
  localparam logic [15:0] STAT_IDX = 16'h0002;
  localparam logic [15:0] KEEP_IDX = 16'h0003;

  localparam int          CFG_W      = 14;
  localparam logic [13:0] CFG_RST    = 14'h3fff;
  localparam logic [13:0] CFG_FIXED1 = 14'h0080;
  localparam int OSC_LSB   = 0;
  localparam int WATCHDOG_ENABLE_BIT  = 2;
  localparam int POWERUP_TIMER_ENABLE_N_BIT = 3;
  localparam int CP_LSB    = 4;
  localparam int BROWNOUT_ENABLE_BIT = 6;
  localparam logic [1:0] CP_OFF   = 2'h3;
  localparam logic [1:0] CP_UPPER = 2'h2;
  localparam logic [1:0] CP_ALL   = 2'h0;

  localparam int CTRL_DIR_LSB    = 0;
  localparam int CTRL_ADC_BIT    = 8;
  localparam int CTRL_GIE_BIT    = 9;
  localparam int CTRL_SLEEP_BIT  = 10;
  localparam int CTRL_CLRWDT_BIT = 11;
  localparam int STAT_PC_LSB     = 0;
  localparam int STAT_TO_BIT     = 13;
  localparam int STAT_PD_BIT     = 14;
  localparam int STAT_CAUSE_LSB  = 15;
  localparam int STAT_STATE_LSB  = 18;

  typedef enum logic [1:0] {
    OSC_LOW_POWER = 2'h0,
    OSC_STANDARD  = 2'h1,
    OSC_HIGH_SPD  = 2'h2,
    OSC_RC        = 2'h3
  } rcs_osc_t;

  typedef enum logic [2:0] {
    ST_LOAD  = 3'h0,
    ST_HOLD  = 3'h1,
    ST_RUN   = 3'h2,
    ST_SLEEP = 3'h3,
    ST_WAKE  = 3'h4
  } rcs_state_t;

  typedef enum logic [2:0] {
    CAUSE_POWER_ON   = 3'h0,
    CAUSE_BROWNOUT   = 3'h1,
    CAUSE_PIN_RUN    = 3'h2,
    CAUSE_PIN_SLEEP  = 3'h3,
    CAUSE_WDOG_RESET = 3'h4,
    CAUSE_WDOG_WAKE  = 3'h5,
    CAUSE_IRQ_WAKE   = 3'h6
  } rcs_cause_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_CFG  = 3'h1,
    SEL_CTRL = 3'h2,
    SEL_STAT = 3'h3,
    SEL_KEEP = 3'h4
  } rcs_sel_t;

  typedef struct packed {
    logic [1:0] code_protect_field;
    logic       brownout_enable;
    logic       powerup_timer_enable_n;
    logic       watchdog_enable;
    rcs_osc_t   osc_select;
  } rcs_cfg_t;

  function automatic rcs_cfg_t rcs_decode(input logic [13:0] w);
    rcs_cfg_t c;
    c.code_protect_field     = w[CP_LSB +: 2];
    c.brownout_enable        = w[BROWNOUT_ENABLE_BIT];
    c.powerup_timer_enable_n = w[POWERUP_TIMER_ENABLE_N_BIT];
    c.watchdog_enable        = w[WATCHDOG_ENABLE_BIT];
    c.osc_select             = rcs_osc_t'(w[OSC_LSB +: 2]);
    return c;
  endfunction

  function automatic rcs_sel_t rcs_select(input logic [15:0] a);
    rcs_sel_t s;
    s = SEL_NONE;
    if (a == {CFG_IDX[13:0], 2'h0})  s = SEL_CFG;
    if (a == {CTRL_IDX[13:0], 2'h0}) s = SEL_CTRL;
    if (a == {STAT_IDX[13:0], 2'h0}) s = SEL_STAT;
    if (a == {KEEP_IDX[13:0], 2'h0}) s = SEL_KEEP;
    return s;
  endfunction
endpackage

// ==== hw/rcs_top.sv ====
/*
  Reset and configuration sequencer: configuration word decode, reset
  source arbitration, start-up delays, sleep and wake-up, reset cause.
  Assumes all inputs synchronous to REF_CLK_IN and an APB master.
*/
// What this block does
// - Configuration word at 2007h, programmed reads 0
// - Configuration space reachable only in programming mode
// - Protect field: 11 off, 10 upper, 00 all
// - Bit 6 enables brown-out reset
// - Watchdog disabled only by configuration bit
// - Crystal modes wait 1024 periods on power-up, brown-out and wake; RC skips it
// - Power-up timer delay only on power-up and brown-out
// - Sleep ends on pin reset, watchdog, interrupt
// - Resets load registers; watchdog wake leaves them
// - Some registers kept through all non-power resets
// - Short master clear pulses are filtered out
// - Internal resets never drive master clear pin
// - Reset PC 0; wake PC+1 or vector 0004h
// - Interrupt wake with irqs off resumes in line
// - Timeout and powerdown flags show reset cause
// - Any reset makes port pins inputs
// - Interrupt wake leaves interrupt flags set
// - Reset turns converter off, aborts conversion
module rcs_top #(
  parameter int unsigned POWERUP_TIMER_CYC = rcs_pkg::POWERUP_TIMER_CYC_DEF,
  parameter int unsigned WDT_CYC  = rcs_pkg::WDT_CYC_DEF
) (
  input  wire logic                 REF_CLK_IN,
  input  wire logic                 RST_IN,
  input  wire logic                 PSEL_IN,
  input  wire logic                 PENABLE_IN,
  input  wire logic                 PWRITE_IN,
  input  wire logic [15:0]          PADDR_IN,
  input  wire logic [31:0]          PWDATA_IN,
  output logic [31:0]               PRDATA_OUT,
  output logic                      PREADY_OUT,
  output logic                      PSLVERR_OUT,
  input  wire logic                 MASTER_CLEAR_PIN_N_IN,
  output logic                      MASTER_CLEAR_PIN_OUT,
  output logic                      MASTER_CLEAR_PIN_OE_OUT,
  input  wire logic                 BROWNOUT_IN,
  input  wire logic                 PROG_MODE_IN,
  input  wire logic                 IRQ_PENDING_IN,
  input  wire logic [12:0]          CORE_PC_IN,
  output logic                      CORE_RESET_OUT,
  output logic                      SLEEPING_OUT,
  output logic                      PC_LOAD_OUT,
  output logic [12:0]               PC_OUT,
  output logic                      TIMEOUT_FLAG_N_OUT,
  output logic                      POWERDOWN_FLAG_N_OUT,
  output rcs_pkg::rcs_cause_t       RESET_CAUSE_OUT,
  output logic [7:0]                PORT_DIR_OUT,
  output logic                      ADC_ON_OUT,
  output logic                      GLOBAL_IRQ_ENABLE_OUT,
  output rcs_pkg::rcs_cfg_t         CFG_OUT,
  output logic                      PROTECT_UPPER_OUT,
  output logic                      PROTECT_ALL_OUT
);
  import rcs_pkg::*;

  rcs_state_t         st_q;
  logic [DLY_W-1:0]   dly_q;
  logic               pwr_q, pc_load_q;
  logic [13:0]        cfg_q;
  rcs_cfg_t           cfg;
  logic [7:0]         dir_q;
  logic               adc_q, gie_q;
  logic [31:0]        keep_q, prdata_q, rd_word;
  logic [MASTER_CLEAR_PIN_W-1:0]  master_clear_pin_cnt_q;
  logic [DLY_W-1:0]   wdt_q;
  logic               to_n_q, pd_n_q;
  rcs_cause_t         cause_q;
  logic [12:0]        pc_q;
  rcs_sel_t           sel;
  logic               powerup_timer_on, crystal, master_clear_pin_act, bor_act, hard;
  logic               wdt_to, in_rst, bad, wr, ctrl_wr, clr_req;
  logic               ev_sleep, ev_master_clear_pin, ev_wdt_rst, ev_wdt_wake;
  logic               ev_irq_wake, boot_done, wake_done;

  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  assign cfg      = rcs_decode(cfg_q);
  assign powerup_timer_on  = cfg.brownout_enable | ~cfg.powerup_timer_enable_n;
  assign crystal  = cfg.osc_select != OSC_RC;
  assign bor_act  = BROWNOUT_IN & cfg.brownout_enable;
  assign master_clear_pin_act = master_clear_pin_cnt_q == MASTER_CLEAR_PIN_W'(MASTER_CLEAR_PIN_MIN_CYC);
  assign hard     = bor_act | master_clear_pin_act;
  assign wdt_to   = cfg.watchdog_enable
                    & (wdt_q == DLY_W'(WDT_CYC - 1));
  assign in_rst   = (st_q == ST_LOAD) || (st_q == ST_HOLD);

  assign sel     = rcs_select(PADDR_IN);
  assign bad     = (sel == SEL_NONE)
                   || ((sel == SEL_CFG) && !PROG_MODE_IN);
  assign wr      = PSEL_IN & PENABLE_IN & PWRITE_IN & ~bad;
  assign ctrl_wr = wr && (sel == SEL_CTRL) && !in_rst;
  assign clr_req = ctrl_wr & PWDATA_IN[CTRL_CLRWDT_BIT];

  assign ev_sleep    = ctrl_wr && PWDATA_IN[CTRL_SLEEP_BIT]
                       && (st_q == ST_RUN) && !hard && !wdt_to;
  assign ev_master_clear_pin     = master_clear_pin_act && !bor_act && !in_rst;
  assign ev_wdt_rst  = wdt_to && (st_q == ST_RUN) && !hard;
  assign ev_wdt_wake = wdt_to && (st_q == ST_SLEEP) && !hard;
  assign ev_irq_wake = IRQ_PENDING_IN && (st_q == ST_SLEEP)
                       && !hard && !wdt_to;
  assign boot_done   = (st_q == ST_HOLD) && (dly_q == '0) && !hard;
  assign wake_done   = (st_q == ST_WAKE) && (dly_q == '0) && !hard;

  // Internal reset sources have no path to the pin
  assign MASTER_CLEAR_PIN_OUT    = 1'b0;
  assign MASTER_CLEAR_PIN_OE_OUT = 1'b0;

  // Pin filter: only a low level lasting the full width counts
  always_ff @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      master_clear_pin_cnt_q <= '0;
    else if (MASTER_CLEAR_PIN_N_IN)
      master_clear_pin_cnt_q <= '0;
    else if (!master_clear_pin_act)
      master_clear_pin_cnt_q <= master_clear_pin_cnt_q + MASTER_CLEAR_PIN_W'(1);
  end

  // Sequencer: LOAD computes the delay, HOLD counts it down
  always_ff @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      st_q  <= ST_LOAD;
      dly_q <= '0;
      pwr_q <= 1'b1;
    end
    else
    begin
      case (st_q)
        ST_LOAD:
        begin
          dly_q <= (pwr_q && powerup_timer_on ? DLY_W'(POWERUP_TIMER_CYC) : '0)
                   + (pwr_q && crystal ? DLY_W'(OST_TOSC) : '0);
          if (!hard)
            st_q <= ST_HOLD;
        end
        ST_HOLD, ST_WAKE:
        begin
          if (hard)
            st_q <= ST_LOAD;
          else if (dly_q == '0)
            st_q <= ST_RUN;
          else
            dly_q <= dly_q - DLY_W'(1);
        end
        ST_RUN:
        begin
          if (hard || ev_wdt_rst)
            st_q <= ST_LOAD;
          else if (ev_sleep)
            st_q <= ST_SLEEP;
        end
        ST_SLEEP:
        begin
          if (hard)
            st_q <= ST_LOAD;
          else if (ev_wdt_wake || ev_irq_wake)
          begin
            st_q  <= ST_WAKE;
            dly_q <= crystal ? DLY_W'(OST_TOSC) : '0;
          end
        end
        default:
          st_q <= ST_LOAD;
      endcase
      if (bor_act)
        pwr_q <= 1'b1;
      else if (boot_done)
        pwr_q <= 1'b0;
    end
  end

  // Reset cause and the two status flags
  always_ff @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      to_n_q  <= 1'b1;
      pd_n_q  <= 1'b1;
      cause_q <= CAUSE_POWER_ON;
    end
    else if (bor_act)
    begin
      to_n_q  <= 1'b1;
      pd_n_q  <= 1'b1;
      cause_q <= CAUSE_BROWNOUT;
    end
    else if (ev_master_clear_pin)
      cause_q <= (st_q == ST_RUN) ? CAUSE_PIN_RUN : CAUSE_PIN_SLEEP;
    else if (ev_wdt_rst)
    begin
      to_n_q  <= 1'b0;
      cause_q <= CAUSE_WDOG_RESET;
    end
    else if (ev_wdt_wake)
    begin
      to_n_q  <= 1'b0;
      pd_n_q  <= 1'b0;
      cause_q <= CAUSE_WDOG_WAKE;
    end
    else if (ev_irq_wake)
      cause_q <= CAUSE_IRQ_WAKE;
    else if (ev_sleep)
    begin
      to_n_q <= 1'b1;
      pd_n_q <= 1'b0;
    end
    else if (clr_req)
    begin
      to_n_q <= 1'b1;
      pd_n_q <= 1'b1;
    end
  end

  // Watchdog: only the configuration bit stops it, software only clears
  always_ff @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      wdt_q <= '0;
    else if (!cfg.watchdog_enable || in_rst || st_q == ST_WAKE
             || ev_sleep || clr_req || wdt_to)
      wdt_q <= '0;
    else
      wdt_q <= wdt_q + DLY_W'(1);
  end

  // Registers with a reset state; a wake-up leaves them alone
  always_ff @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      dir_q <= DIR_RST;
      adc_q <= 1'b0;
      gie_q <= 1'b0;
    end
    else if (in_rst)
    begin
      dir_q <= DIR_RST;
      adc_q <= 1'b0;
      gie_q <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      dir_q <= PWDATA_IN[CTRL_DIR_LSB +: 8];
      adc_q <= PWDATA_IN[CTRL_ADC_BIT];
      gie_q <= PWDATA_IN[CTRL_GIE_BIT];
    end
  end

  // Configuration word and the register that survives device resets
  always_ff @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      cfg_q  <= CFG_RST;
      keep_q <= '0;
    end
    else
    begin
      if (wr && sel == SEL_CFG)
        cfg_q <= PWDATA_IN[CFG_W-1:0] | CFG_FIXED1;
      if (wr && sel == SEL_KEEP)
        keep_q <= PWDATA_IN;
    end
  end

  // Program counter value handed to the core on release or wake
  always_ff @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      pc_q      <= PC_RESET;
      pc_load_q <= 1'b0;
    end
    else
    begin
      pc_load_q <= boot_done | wake_done;
      if (in_rst)
        pc_q <= PC_RESET;
      else if (ev_sleep)
        pc_q <= CORE_PC_IN;
      else if (wake_done)
        pc_q <= (cause_q == CAUSE_IRQ_WAKE && gie_q)
                ? PC_VECTOR : pc_q + 13'h0001;
    end
  end

  always_comb
  begin
    rd_word = '0;
    case (sel)
      SEL_CFG:
        rd_word[CFG_W-1:0] = cfg_q;
      SEL_CTRL:
      begin
        rd_word[CTRL_DIR_LSB +: 8] = dir_q;
        rd_word[CTRL_ADC_BIT]      = adc_q;
        rd_word[CTRL_GIE_BIT]      = gie_q;
      end
      SEL_STAT:
      begin
        rd_word[STAT_PC_LSB +: PC_W]  = pc_q;
        rd_word[STAT_TO_BIT]          = to_n_q;
        rd_word[STAT_PD_BIT]          = pd_n_q;
        rd_word[STAT_CAUSE_LSB +: 3]  = cause_q;
        rd_word[STAT_STATE_LSB +: 3]  = st_q;
      end
      SEL_KEEP:
        rd_word = keep_q;
      default:
        rd_word = '0;
    endcase
  end

  // Read data captured in the setup phase; protected space reads zero
  always_ff @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      prdata_q <= '0;
    else if (PSEL_IN && !PENABLE_IN)
      prdata_q <= bad ? '0 : rd_word;
  end

  assign PRDATA_OUT            = prdata_q;
  assign PREADY_OUT            = 1'b1;
  assign PSLVERR_OUT           = PSEL_IN & PENABLE_IN & bad;
  assign CORE_RESET_OUT        = in_rst;
  assign SLEEPING_OUT          = st_q == ST_SLEEP;
  assign PC_LOAD_OUT           = pc_load_q;
  assign PC_OUT                = pc_q;
  assign TIMEOUT_FLAG_N_OUT    = to_n_q;
  assign POWERDOWN_FLAG_N_OUT  = pd_n_q;
  assign RESET_CAUSE_OUT       = cause_q;
  assign PORT_DIR_OUT          = dir_q;
  assign ADC_ON_OUT            = adc_q;
  assign GLOBAL_IRQ_ENABLE_OUT = gie_q;
  assign CFG_OUT               = cfg;
  assign PROTECT_UPPER_OUT     = cfg.code_protect_field != CP_OFF;
  assign PROTECT_ALL_OUT       = cfg.code_protect_field == CP_ALL;

  a_pin_never_driven: assert property (
    !MASTER_CLEAR_PIN_OE_OUT && !MASTER_CLEAR_PIN_OUT)
    else $error("master clear pin driven");
  a_pin_filter_width: assert property (
    $rose(master_clear_pin_act) |-> !$past(MASTER_CLEAR_PIN_N_IN)
      && !$past(MASTER_CLEAR_PIN_N_IN, 2))
    else $error("short pin pulse caused reset");
  a_reset_regs: assert property (
    in_rst |=> PORT_DIR_OUT == DIR_RST && !ADC_ON_OUT && PC_OUT == '0)
    else $error("reset state not loaded");
  a_wdog_wake_keep: assert property (
    ev_wdt_wake |=> $stable(PORT_DIR_OUT) && $stable(ADC_ON_OUT)
      && st_q == ST_WAKE)
    else $error("watchdog wake changed registers");
  a_wdog_wake_flags: assert property (
    ev_wdt_wake |=> !TIMEOUT_FLAG_N_OUT && !POWERDOWN_FLAG_N_OUT)
    else $error("flags wrong after watchdog wake");
  a_irq_vector: assert property (
    (wake_done && cause_q == CAUSE_IRQ_WAKE && gie_q)
      |=> PC_LOAD_OUT && PC_OUT == PC_VECTOR)
    else $error("interrupt wake did not vector");
  a_irq_inline: assert property (
    (wake_done && !gie_q)
      |=> PC_LOAD_OUT && PC_OUT == $past(pc_q) + 13'h0001)
    else $error("wake did not resume in line");
  a_rc_no_wait: assert property (
    (ev_irq_wake && !crystal) |=> ##1 (st_q == ST_RUN || hard))
    else $error("RC mode wake was delayed");
  a_crystal_wait: assert property (
    (ev_irq_wake && crystal) |=> dly_q == DLY_W'(OST_TOSC))
    else $error("crystal wake delay wrong");
  a_cfg_locked: assert property (
    (PSEL_IN && PENABLE_IN && sel == SEL_CFG && !PROG_MODE_IN)
      |-> PSLVERR_OUT ##1 $stable(cfg_q))
    else $error("configuration changed outside programming");
  a_brownout_timer: assert property (
    (st_q == ST_LOAD && pwr_q && cfg.brownout_enable)
      |=> dly_q >= DLY_W'(POWERUP_TIMER_CYC))
    else $error("power-up delay missing");
  a_wdog_off: assert property (
    !cfg.watchdog_enable |=> wdt_q == '0 && !ev_wdt_rst)
    else $error("watchdog ran while disabled");

  c_irq_wake:  cover property (ev_irq_wake ##[1:1000] wake_done);
  c_wdog_wake: cover property (ev_wdt_wake);
  c_pin_reset: cover property (ev_master_clear_pin ##[1:40] boot_done);
  c_brownout:  cover property ($rose(bor_act));
endmodule

// ==== testbench/rcs_ext_src.sv ====
/*
  Model of the parties outside the sequencer: the external master
  clear source and the supply monitor.
  Assumes the bench's reference clock and tasks called after an edge.
*/
module rcs_ext_src (
  input  wire logic clk_in,
  output logic      master_clear_pin_n_out,
  output logic      brownout_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pin rests at its pull-up level, supply monitor reports good supply
  initial
  begin
    master_clear_pin_n_out   = 1'b1;
    brownout_out = 1'b0;
  end

  // Holds the pin low for the given number of sampled cycles
  task automatic master_clear_pin_low(input int cycles);
    @(posedge clk_in);
    master_clear_pin_n_out <= 1'b0;
    repeat (cycles) @(posedge clk_in);
    master_clear_pin_n_out <= 1'b1;
  endtask

  task automatic supply_dip(input int cycles);
    @(posedge clk_in);
    brownout_out <= 1'b1;
    repeat (cycles) @(posedge clk_in);
    brownout_out <= 1'b0;
  endtask
endmodule

// ==== testbench/test_reset_config_sequencer.sv ====
/*
  Self-checking bench of the reset and configuration sequencer.
  Assumes rcs_pkg, rcs_top and the rcs_ext_src model of the far side.
*/
module test_reset_config_sequencer;
  import rcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int          PW     = 50;
  localparam int          WD     = 200;
  localparam logic [15:0] A_CFG  = {CFG_IDX[13:0], 2'h0};
  localparam logic [15:0] A_CTRL = {CTRL_IDX[13:0], 2'h0};
  localparam logic [15:0] A_KEEP = {KEEP_IDX[13:0], 2'h0};
  localparam logic [15:0] A_STAT = {STAT_IDX[13:0], 2'h0};

  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic        psel   = 1'b0;
  logic        pen    = 1'b0;
  logic        pwr    = 1'b0;
  logic [15:0] paddr  = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        prog   = 1'b0;
  logic        irq    = 1'b0;
  logic [12:0] cpc    = 13'h0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, master_clear_pin_n, bo, master_clear_pin_o, master_clear_pin_oe, err;
  logic        core_rst, sleeping, pc_load, to_n, pd_n, adc, global_irq_enable, pu, pa;
  logic [12:0] pc;
  logic [7:0]  dir;
  rcs_cause_t  cause;
  rcs_cfg_t    cfg;
  int          n;
  int          fails       = 0;
  int          checks_done = 0;
  int          cycles      = 0;

  always #50 clk = ~clk;

  rcs_ext_src EXT (.clk_in(clk), .master_clear_pin_n_out(master_clear_pin_n), .brownout_out(bo));

  rcs_top #(.POWERUP_TIMER_CYC(PW), .WDT_CYC(WD)) DUT (
    .REF_CLK_IN(clk), .RST_IN(rst),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .MASTER_CLEAR_PIN_N_IN(master_clear_pin_n), .MASTER_CLEAR_PIN_OUT(master_clear_pin_o),
    .MASTER_CLEAR_PIN_OE_OUT(master_clear_pin_oe), .BROWNOUT_IN(bo),
    .PROG_MODE_IN(prog), .IRQ_PENDING_IN(irq), .CORE_PC_IN(cpc),
    .CORE_RESET_OUT(core_rst), .SLEEPING_OUT(sleeping),
    .PC_LOAD_OUT(pc_load), .PC_OUT(pc), .TIMEOUT_FLAG_N_OUT(to_n),
    .POWERDOWN_FLAG_N_OUT(pd_n), .RESET_CAUSE_OUT(cause),
    .PORT_DIR_OUT(dir), .ADC_ON_OUT(adc), .GLOBAL_IRQ_ENABLE_OUT(global_irq_enable),
    .CFG_OUT(cfg), .PROTECT_UPPER_OUT(pu), .PROTECT_ALL_OUT(pa)
  );

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      fails = fails + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  // hi holds clear-watchdog, sleep, interrupt enable, converter on
  task automatic ctrl(input logic [3:0] hi, input logic [7:0] d);
    apb(1'b1, A_CTRL, {20'h0, hi, d});
  endtask

  task automatic cfg_wr(input logic [13:0] w);
    @(posedge clk);
    prog <= 1'b1;
    apb(1'b1, A_CFG, {18'h0, w});
    apb(1'b0, A_CFG, 32'h0);
    prog <= 1'b0;
    chk(rd, {18'h0, w | CFG_FIXED1});
    chk({23'h0, cfg, pu, pa}, {23'h0, w[5:4], w[6], w[3], w[2], w[1:0],
        w[5:4] != 2'h3, w[5:4] == 2'h0});
  endtask

  task automatic wait_load(output int k);
    k = 0;
    while (pc_load !== 1'b1 && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic boot(input int lo, input int hi, input rcs_cause_t c);
    wait_load(n);
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
    chk({18'h0, core_rst, pc}, {18'h0, 1'b0, PC_RESET});
    chk({23'h0, dir, adc}, {23'h0, DIR_RST, 1'b0});
    chk({29'h0, cause}, {29'h0, c});
  endtask

  task automatic nap(input logic g, input logic [12:0] p);
    cpc <= p;
    ctrl({2'b01, g, 1'b1}, 8'h3c);
    n = 0;
    while (sleeping !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    chk({30'h0, to_n, pd_n}, 32'h2);
  endtask

  task automatic woke(input logic g, input rcs_cause_t c, input int lo,
                      input int hi);
    wait_load(n);
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
    chk({19'h0, pc}, {19'h0, (g && c == CAUSE_IRQ_WAKE) ? PC_VECTOR
        : cpc + 13'h1});
    chk({19'h0, cause, dir, global_irq_enable, adc},
        {19'h0, c, 8'h3c, g, 1'b1});
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    boot(PW, PW + 6, CAUSE_POWER_ON);
    chk({30'h0, to_n, pd_n}, 32'h3);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd, {11'h0, ST_RUN, CAUSE_POWER_ON, 2'b11, PC_RESET});
    $display("power-on test finished");
    apb(1'b0, A_CFG, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b0, 16'h0010, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 4; i++)
      cfg_wr({7'h00, i[0], i[1:0], ~i[0], 1'b0, i[1:0]});
    apb(1'b1, A_CFG, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk({23'h0, cfg, pu, pa}, 32'h1cc);
    apb(1'b1, A_KEEP, 32'hcafe_1234);
    $display("register test finished");
    cfg_wr(14'h003b);
    EXT.supply_dip(10);
    repeat (8) @(posedge clk);
    chk({31'h0, core_rst}, 32'h0);
    cfg_wr(14'h007b);
    ctrl(4'h1, 8'h5a);
    EXT.supply_dip(10);
    boot(PW, PW + 6, CAUSE_BROWNOUT);
    chk({30'h0, to_n, pd_n}, 32'h3);
    $display("brown-out test finished");
    ctrl(4'h1, 8'h5a);
    EXT.master_clear_pin_low(MASTER_CLEAR_PIN_MIN_CYC - 1);
    repeat (4) @(posedge clk);
    chk({23'h0, dir, core_rst}, {23'h0, 8'h5a, 1'b0});
    EXT.master_clear_pin_low(MASTER_CLEAR_PIN_MIN_CYC + 5);
    boot(1, 6, CAUSE_PIN_RUN);
    chk({30'h0, master_clear_pin_o, master_clear_pin_oe}, 32'h0);
    $display("pin reset test finished");
    for (int g = 0; g < 2; g++)
    begin
      nap(g[0], 13'h0120);
      irq <= 1'b1;
      woke(g[0], CAUSE_IRQ_WAKE, 1, 6);
      irq <= 1'b0;
    end
    cfg_wr(14'h0039);
    nap(1'b0, 13'h1fff);
    irq <= 1'b1;
    woke(1'b0, CAUSE_IRQ_WAKE, OST_TOSC, OST_TOSC + 6);
    irq <= 1'b0;
    nap(1'b0, 13'h0040);
    EXT.master_clear_pin_low(MASTER_CLEAR_PIN_MIN_CYC + 5);
    boot(1, 6, CAUSE_PIN_SLEEP);
    $display("sleep test finished");
    cfg_wr(14'h003f);
    ctrl(4'h1, 8'h5a);
    boot(1, WD + 10, CAUSE_WDOG_RESET);
    chk({31'h0, to_n}, 32'h0);
    ctrl(4'h9, 8'h5a);
    @(posedge clk);
    chk({30'h0, to_n, pd_n}, 32'h3);
    nap(1'b0, 13'h0aaa);
    woke(1'b0, CAUSE_WDOG_WAKE, 1, WD + 10);
    chk({30'h0, to_n, pd_n}, 32'h0);
    cfg_wr(14'h003b);
    apb(1'b0, A_KEEP, 32'h0);
    chk(rd, 32'hcafe_1234);
    $display("watchdog test finished");
    stop_test();
  end
endmodule
